// file: hdl/serial_word_params.svh
`ifndef SERIAL_WORD_PARAMS_SVH
`define SERIAL_WORD_PARAMS_SVH

// ----------------------------------------
// Word layout and address codes
// ----------------------------------------
`define WORD_W 24
`define ADDR_TWO_W 2
`define ADDR_THREE_W 3
`define ADDR_FOUR_W 4
`define ADDR_FIVE_W 5
`define ADDR_ONE 2'h1
`define ADDR_TWO 2'h2
`define ADDR_THREE 3'h3
`define ADDR_FOUR 4'h7
`define ADDR_FIVE 5'h0f
`define DEF_SEL_BIT 23

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WORD_TWO_DEFAULT 24'hc87806
`define WORD_ZERO_RESET 24'h000000
`define DEF_SEL_RESET 1'h1

`endif

// file: hdl/serial_word_pkg.sv
package serial_word_pkg;
  typedef enum logic [4:0] {
    SEL_NONE = 5'h01,
    SEL_TWO = 5'h02,
    SEL_THREE = 5'h04,
    SEL_FOUR = 5'h08,
    SEL_FIVE = 5'h10
  } word_sel_t;
endpackage

// file: hdl/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: hdl/synth_serial_word.sv
// Functional notes
// - Low bits 011 select word three.
// - Low bits 0111 select word four.
// - Low bits 01111 select word five.
// - Words three to five need default-select clear.
// - Word two resets to fixed default pattern.
// - Default-select picks built-in or programmed word two.
// - Low bits 10 select word two.
`timescale 1ns/1ns
`default_nettype none
`include "serial_word_params.svh"
module synth_serial_word
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic serial_data,
  input wire logic serial_clk,
  input wire logic word_latch_strobe,
  output logic default_set_select,
  output logic [23:0] config_word_two,
  output logic [23:0] config_word_three,
  output logic [23:0] config_word_four,
  output logic [23:0] config_word_five,
  output logic [23:0] active_word_two
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic data_s;
  logic clk_s;
  logic latch_s;
  pin_sync u_sync_data (.clk(ref_clk), .rst_n(rst_n), .d(serial_data),
    .q(data_s));
  pin_sync u_sync_clk (.clk(ref_clk), .rst_n(rst_n), .d(serial_clk),
    .q(clk_s));
  pin_sync u_sync_latch (.clk(ref_clk), .rst_n(rst_n),
    .d(word_latch_strobe), .q(latch_s));

  logic clk_d_r;
  logic latch_d_r;
  logic [23:0] shift_r;
  logic [23:0] shift_nxt;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_d_r <= 1'b0;
      latch_d_r <= 1'b0;
    end
    else
    begin
      clk_d_r <= clk_s;
      latch_d_r <= latch_s;
    end
  end

  wire clk_rise = clk_s & ~clk_d_r;
  wire latch_rise = latch_s & ~latch_d_r;

  // ----------------------------------------
  // Shift register
  // ----------------------------------------
  // MSB-first shift
  assign shift_nxt = clk_rise ? {shift_r[22:0], data_s} : shift_r;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_r <= `WORD_ZERO_RESET;
    else
      shift_r <= shift_nxt;
  end

  property p_shift_msb;
    @(posedge ref_clk) disable iff (!rst_n)
    clk_rise |=> shift_r[0] == $past(data_s)
      && shift_r[23:1] == $past(shift_r[22:0]);
  endproperty
  a_shift_msb: assert property (p_shift_msb)
    else $error("serial shift wrong");

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // word two code
  wire hit_two = shift_r[1:0] == `ADDR_TWO;
  wire hit_three = shift_r[2:0] == `ADDR_THREE;
  wire hit_four = shift_r[3:0] == `ADDR_FOUR;
  wire hit_five = shift_r[4:0] == `ADDR_FIVE;
  wire hit_one = shift_r[1:0] == `ADDR_ONE;

  serial_word_pkg::word_sel_t sel;
  assign sel = hit_two ? serial_word_pkg::SEL_TWO :
    hit_five ? serial_word_pkg::SEL_FIVE :
    hit_four ? serial_word_pkg::SEL_FOUR :
    hit_three ? serial_word_pkg::SEL_THREE : serial_word_pkg::SEL_NONE;

  wire prog_ok = ~default_set_select;
  wire wr_one = latch_rise & hit_one;
  wire wr_two = latch_rise & (sel == serial_word_pkg::SEL_TWO);
  wire wr_three = latch_rise & prog_ok & (sel == serial_word_pkg::SEL_THREE);
  wire wr_four = latch_rise & prog_ok & (sel == serial_word_pkg::SEL_FOUR);
  wire wr_five = latch_rise & prog_ok & (sel == serial_word_pkg::SEL_FIVE);

  // ----------------------------------------
  // Configuration words
  // ----------------------------------------
  // update on latch pulse
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      default_set_select <= `DEF_SEL_RESET;
    else if (wr_one)
      default_set_select <= shift_r[`DEF_SEL_BIT];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      config_word_two <= `WORD_TWO_DEFAULT;
    else if (wr_two)
      config_word_two <= shift_r;
  end

  property p_two_store;
    @(posedge ref_clk) disable iff (!rst_n)
    (latch_rise && shift_r[1:0] == 2'h2)
    |=> config_word_two == $past(shift_r);
  endproperty
  a_two_store: assert property (p_two_store)
    else $error("word two not stored");

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      config_word_three <= `WORD_ZERO_RESET;
    else if (wr_three)
      config_word_three <= shift_r;
  end

  property p_three_blocked;
    @(posedge ref_clk) disable iff (!rst_n)
    (latch_rise && default_set_select) |=> $stable(config_word_three);
  endproperty
  a_three_blocked: assert property (p_three_blocked)
    else $error("word three changed while defaults selected");

  property p_three_store;
    @(posedge ref_clk) disable iff (!rst_n)
    (latch_rise && !default_set_select && shift_r[2:0] == 3'h3)
    |=> config_word_three == $past(shift_r);
  endproperty
  a_three_store: assert property (p_three_store)
    else $error("word three not stored");

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      config_word_four <= `WORD_ZERO_RESET;
    else if (wr_four)
      config_word_four <= shift_r;
  end

  property p_four_store;
    @(posedge ref_clk) disable iff (!rst_n)
    (latch_rise && !default_set_select && shift_r[3:0] == 4'h7)
    |=> config_word_four == $past(shift_r);
  endproperty
  a_four_store: assert property (p_four_store)
    else $error("word four not stored");

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      config_word_five <= `WORD_ZERO_RESET;
    else if (wr_five)
      config_word_five <= shift_r;
  end

  property p_five_store;
    @(posedge ref_clk) disable iff (!rst_n)
    (latch_rise && !default_set_select && shift_r[4:0] == 5'h0f)
    |=> config_word_five == $past(shift_r);
  endproperty
  a_five_store: assert property (p_five_store)
    else $error("word five not stored");

  wire [23:0] active_two_nxt = default_set_select ? `WORD_TWO_DEFAULT :
    config_word_two;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      active_word_two <= `WORD_TWO_DEFAULT;
    else
      active_word_two <= active_two_nxt;
  end

  property p_two_default;
    @(posedge ref_clk) disable iff (!rst_n)
    default_set_select [*2] |-> active_word_two == `WORD_TWO_DEFAULT;
  endproperty
  a_two_default: assert property (p_two_default)
    else $error("word two default wrong");

  property p_active_prog;
    @(posedge ref_clk) disable iff (!rst_n)
    (!default_set_select && $stable(config_word_two))
    |=> active_word_two == $past(config_word_two);
  endproperty
  a_active_prog: assert property (p_active_prog)
    else $error("programmed word two not used");

endmodule
`default_nettype wire

// file: sim/serial_host.sv
`timescale 1ns/1ns
`default_nettype none
module serial_host
(
  input wire logic ref_clk,
  output logic serial_data,
  output logic serial_clk,
  output logic word_latch_strobe
);
  initial
  begin
    serial_data = 1'b0;
    serial_clk = 1'b0;
    word_latch_strobe = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--)
    begin
      serial_data = w[i];
      wait_n(4);
      serial_clk = 1'b1;
      wait_n(4);
      serial_clk = 1'b0;
    end
    serial_data = ~w[0];
    wait_n(4);
    word_latch_strobe = 1'b1;
    wait_n(4);
    word_latch_strobe = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: sim/synth_serial_word_test.sv
`timescale 1ns/1ns
`default_nettype none
module synth_serial_word_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sd, sc, ls, dss_o;
  logic [23:0] w2, w3, w4, w5, act;
  logic [23:0] e2, e3, e4, e5;
  logic [31:0] r;
  logic dss;
  logic [120:0] n;
  logic [120:0] notes[$];
  int seed = 32'h9d88;
  int bad_count = 0;
  int compares = 0;
  event seen_ev;

  always #4 ref_clk = ~ref_clk;

  synth_serial_word i_dut
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .serial_data(sd),
    .serial_clk(sc),
    .word_latch_strobe(ls),
    .default_set_select(dss_o),
    .config_word_two(w2),
    .config_word_three(w3),
    .config_word_four(w4),
    .config_word_five(w5),
    .active_word_two(act)
  );

  serial_host i_host
  (
    .ref_clk(ref_clk),
    .serial_data(sd),
    .serial_clk(sc),
    .word_latch_strobe(ls)
  );

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("bad_count %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic note();
    notes.push_back({dss, e2, e3, e4, e5, dss ? 24'hc87806 : e2});
    -> seen_ev;
  endtask

  task automatic put(input logic [23:0] w);
    i_host.send_word(w);
    if (w[1:0] == 2'h2)
      e2 = w;
    else if (w[1:0] == 2'h1)
      dss = w[23];
    else if (!dss && w[4:0] == 5'h0f)
      e5 = w;
    else if (!dss && w[3:0] == 4'h7)
      e4 = w;
    else if (!dss && w[2:0] == 3'h3)
      e3 = w;
    i_host.wait_n(8);
    note();
  endtask

  always @(seen_ev)
  begin
    n = notes.pop_front();
    check({23'h0, dss_o}, {23'h0, n[120]});
    check(w2, n[119:96]);
    check(w3, n[95:72]);
    check(w4, n[71:48]);
    check(w5, n[47:24]);
    check(act, n[23:0]);
  end

  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    e2 = 24'hc87806;
    {e3, e4, e5, dss} = {72'h0, 1'b1};
    note();
    put(24'h86801b);
    r = $random(seed);
    put({1'b0, r[20:0], 2'h1});
    put(24'h86801b);
    put(24'h03a327);
    r = $random(seed);
    put({r[23:5], 5'h0f});
    r = $random(seed);
    put({r[23:2], 2'h2});
    repeat (6)
    begin
      r = $random(seed);
      put(r[23:0]);
    end
    r = $random(seed);
    put({1'b1, r[20:0], 2'h1});
    put({r[23:5], 5'h0f});
    put({r[23:3], 3'h3});
    rst_n = 1'b0;
    i_host.wait_n(2);
    rst_n = 1'b1;
    e2 = 24'hc87806;
    {e3, e4, e5, dss} = {72'h0, 1'b1};
    note();
    r = $random(seed);
    put({r[23:2], 2'h2});
    wrap_up();
  end

  initial
  begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
